// ===== mrd_regs.sv
// Behaviour
// R1: diode results readable at 0x02, 0x03
// R2: result bits 14:12 carry channel tag
// R3: result bit 11 flags open diode
// R4: result bits 10:0 two's complement temperature
// R5: results refresh about every 5 ms
// R6: internal result 0x04, flag bit15, 14:11 zero
// R7: bit10 weighs -256, bit0 0.25 degrees
// R8: writes 0x01..0x04 load output codes A..D
// R9: code from bits 11:0, upper byte first
// R10: code write bits 15:12 ignored
// R11: three 8-bit alert status registers 0x05..0x07
// R12: host reads status to find alert cause
// R13: writing 0xFF clears whole status register
// R14: writing one clears that single alert bit
// R15: setup bits 1 and 2 clear all
// R16: combined clear keeps alert pin enabled afterwards
// R17: sequence register 0x08 selects autocycle channels
// R18: setup register 0x09 sets operating mode
// R19: setup register resets to 0x0000
// R20: adc result 0x01: flag, tag, 12 bits
// R21: tags: inputs 000-011, current 10x, diodes 11x
// R22: alert bits stay set until cleared
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module mrd_regs #(
  parameter int REFRESH_CYCLES_P = mrd_pkg::REFRESH_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // register bus, one classic cycle per access
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [mrd_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [mrd_pkg::WB_DAT_W-1:0] wb_dat_i,
  input  wire logic [3:0]                   wb_sel_i,
  output logic      [mrd_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic                              wb_ack_o,
  // converter link pins, asynchronous to clk_i, synchronised inside
  input  wire logic                         link_clk_i,
  input  wire logic                         link_frame_i,
  input  wire logic                         link_data_i,
  // alert events from the conversion logic on the same clock
  input  wire logic [7:0]                   input_alert_set_i,
  input  wire logic [5:0]                   current_alert_set_i,
  input  wire logic [6:0]                   temperature_alert_set_i,
  // registered copies of the writable state, the refresh request and the pin
  output logic      [11:0]                  output_a_code_o,
  output logic      [11:0]                  output_b_code_o,
  output logic      [11:0]                  output_c_code_o,
  output logic      [11:0]                  output_d_code_o,
  output logic      [7:0]                   autocycle_channel_select_o,
  output logic      [15:0]                  operating_setup_o,
  output logic                              conv_req_o,
  output logic                              alert_o
);
  import mrd_pkg::*;

  typedef struct packed {
    // bus answer and captured read data
    logic                   ack;
    logic [WB_DAT_W-1:0]    rdat;
    // output codes a to d, index 0 is a
    logic [3:0][CODE_W-1:0] code;
    // latest results, the adc and diode ones with their channel tags
    logic [14:0]            adc_res;
    logic [14:0]            diode_one;
    logic [14:0]            diode_two;
    logic [TEMP_W-1:0]      int_temp;
    // sticky alert status
    logic [7:0]             st_in;
    logic [7:0]             st_cur;
    logic [7:0]             st_temp;
    // host-writable control
    logic [7:0]             seq;
    logic [15:0]            setup;
    logic                   pin_kept;
    // refresh timer and alert pin
    logic [31:0]            tmr;
    logic                   conv_req;
    logic                   alert;
  } mrd_regs_t;

  mrd_regs_t q;
  mrd_regs_t d;

  // finished link words reach the core through this carrier
  mrd_frame_if frame ();

  // link receiver; its own flops synchronise the pins

  mrd_link_rx u_link_rx (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .link_clk_i   (link_clk_i),
    .link_frame_i (link_frame_i),
    .link_data_i  (link_data_i),
    .frame        (frame.rx)
  );

  // register index from a byte address; bits above the index must be zero
  // misaligned or out-of-range addresses map to an index nothing decodes
  function automatic logic [IDX_W:0] reg_index(input logic [WB_ADR_W-1:0] adr);
    logic [IDX_W:0] r;
    r = {1'b0, adr[IDX_W+1:2]};
    if (adr[WB_ADR_W-1:IDX_W+2] != '0 || adr[1:0] != 2'h0) begin
      r = {1'b1, 4'h0};
    end
    return r;
  endfunction

  // merge a write into an 8-bit field honouring byte lane 0
  function automatic logic [7:0] lane_lo(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
    return sel[0] ? wd[7:0] : old;
  endfunction

  // a write strobe that lands on one register index
  function automatic logic hit(input logic wr_en, input logic [IDX_W:0] at,
                               input logic [3:0] reg_idx);
    return wr_en && (at == {1'b0, reg_idx});
  endfunction

  // sticky status update: clears first, then new events, so a set wins
  function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] clr,
                                     input logic clr_every, input logic [7:0] ev);
    return ((old & ~clr) & {8{!clr_every}}) | ev;
  endfunction

  // helpers of the combinational process, each given a value before it is read
  logic                req;
  logic                wr;
  logic [IDX_W:0]      idx;
  logic                any_alert;
  logic                pin_on;
  logic [7:0]          clr_in;
  logic [7:0]          clr_cur;
  logic [7:0]          clr_temp;
  logic [7:0]          set_temp;
  logic                clr_all;
  logic [15:0]         setup_wr;
  logic [2:0]          ftag;
  logic                open_seen;
  logic [WB_DAT_W-1:0] rd_word;

  always_comb begin
    d          = q;
    d.ack      = 1'b0;
    d.conv_req = 1'b0;
    req        = wb_cyc_i && wb_stb_i && !q.ack;
    wr         = req && wb_we_i;
    idx        = reg_index(wb_adr_i);
    clr_in     = 8'h00;
    clr_cur    = 8'h00;
    clr_temp   = 8'h00;
    clr_all    = 1'b0;
    setup_wr   = q.setup;
    ftag       = frame.word[FRAME_TAG_HI:FRAME_TAG_LO];
    open_seen  = 1'b0;
    any_alert  = (q.st_in != 8'h00) || (q.st_cur != 8'h00) || (q.st_temp != 8'h00);

    // bus answer one cycle after the request; ack drops the cycle after
    if (req) begin
      d.ack = 1'b1;
    end

    // output code writes share indices with the read-only results
    // each code splits into two byte lanes, lane 1 holding the upper bits
    for (int i = 0; i < 4; i++) begin
      if (hit(wr, idx, IDX_OUT_A + 4'(i))) begin  // [R8]
        if (wb_sel_i[1]) begin
          d.code[i][11:8] = wb_dat_i[11:8];  // [R9] upper bits from the first byte
        end
        if (wb_sel_i[0]) begin
          d.code[i][7:0] = wb_dat_i[7:0];  // [R9]
        end
        // bits 15:12 of the written word are never looked at [R10]
      end
    end

    // write-one-to-clear on the alert status registers
    if (hit(wr, idx, IDX_ALERT_IN)) begin
      clr_in = lane_lo(8'h00, wb_dat_i, wb_sel_i);  // [R13] [R14]
    end
    if (hit(wr, idx, IDX_ALERT_CUR)) begin
      clr_cur = lane_lo(8'h00, wb_dat_i, wb_sel_i);  // [R13] [R14]
    end
    if (hit(wr, idx, IDX_ALERT_TEMP)) begin
      clr_temp = lane_lo(8'h00, wb_dat_i, wb_sel_i);  // [R13] [R14]
    end

    // sequence and setup registers
    if (hit(wr, idx, IDX_SEQUENCE)) begin
      d.seq = lane_lo(q.seq, wb_dat_i, wb_sel_i);  // [R17]
    end
    if (hit(wr, idx, IDX_SETUP)) begin
      // lanes merge into the old value, so a one-byte write keeps the other half
      setup_wr[7:0] = lane_lo(q.setup[7:0], wb_dat_i, wb_sel_i);  // [R18]
      if (wb_sel_i[1]) begin
        setup_wr[15:8] = wb_dat_i[15:8];
      end
      d.setup = setup_wr;
      // both pin bits set means clear everything, and the pin stays live after
      if (setup_wr[SETUP_PIN_BIT] && setup_wr[SETUP_CLR_BIT]) begin
        clr_all    = 1'b1;  // [R15]
        d.pin_kept = 1'b1;  // [R16]
      end else if (!setup_wr[SETUP_PIN_BIT]) begin
        // clearing bit 2 hands the pin back to the plain enable
        d.pin_kept = 1'b0;
      end
    end

    // converter link frames update the result registers
    if (frame.valid) begin
      // the internal sensor has no tag or open bit, only the temperature
      if (frame.word[FRAME_INT_BIT]) begin
        d.int_temp = frame.word[TEMP_W-1:0];  // [R4] [R7]
      end else if (ftag[2:1] == TAG_DIODE_PFX) begin
        // an open diode also raises the sticky open-diode status bit
        open_seen = frame.word[RES_OPEN_BIT];
        // the two diodes differ only in the lowest tag bit
        if (ftag[0]) begin
          d.diode_two = {ftag, frame.word[11:0]};  // [R2] [R3] [R4] [R21]
        end else begin
          d.diode_one = {ftag, frame.word[11:0]};  // [R2] [R3] [R4] [R21]
        end
      end else begin
        d.adc_res = {ftag, frame.word[11:0]};  // [R20] [R21]
      end
    end

    // status bits: a set in the same cycle as a clear wins
    // open diode rides on top of the seven temperature events
    set_temp  = {open_seen, temperature_alert_set_i};
    d.st_in   = w1c(q.st_in, clr_in, clr_all, input_alert_set_i);  // [R22]
    // current status bits 7:6 are reserved and never set
    d.st_cur  = w1c(q.st_cur, clr_cur, clr_all,
                    {2'h0, current_alert_set_i} & CUR_ALERT_MASK);  // [R11] [R22]
    d.st_temp = w1c(q.st_temp, clr_temp, clr_all, set_temp);  // [R22]

    // read mux; unmapped indices read as zero
    // result reads carry the live alert summary in bit 15
    rd_word = '0;
    case (idx)
      {1'b0, IDX_ADC_RESULT}: begin
        rd_word[15:0] = {any_alert, q.adc_res};  // [R20]
      end
      {1'b0, IDX_DIODE_ONE}: begin
        rd_word[15:0] = {any_alert, q.diode_one};  // [R1]
      end
      {1'b0, IDX_DIODE_TWO}: begin
        rd_word[15:0] = {any_alert, q.diode_two};  // [R1]
      end
      {1'b0, IDX_INT_TEMP}: begin
        rd_word[15:0] = {any_alert, 4'h0, q.int_temp};  // [R6]
      end
      {1'b0, IDX_ALERT_IN}: begin
        rd_word[7:0] = q.st_in;  // [R11]
      end
      {1'b0, IDX_ALERT_CUR}: begin
        rd_word[7:0] = q.st_cur & CUR_ALERT_MASK;  // [R11]
      end
      {1'b0, IDX_ALERT_TEMP}: begin
        rd_word[7:0] = q.st_temp;  // [R11]
      end
      {1'b0, IDX_SEQUENCE}: begin
        rd_word[7:0] = q.seq;  // [R17]
      end
      {1'b0, IDX_SETUP}: begin
        rd_word[15:0] = q.setup;  // [R18]
      end
      default: begin
        rd_word = '0;
      end
    endcase

    // read data is caught at the taking edge and held until the next read
    if (req && !wb_we_i) begin
      d.rdat = rd_word;
    end

    // free-running refresh request, no host action needed
    // the period is a parameter so a bench can shorten it; it never pauses
    if (q.tmr == 32'(REFRESH_CYCLES_P - 1)) begin
      d.tmr      = 32'h0;
      d.conv_req = 1'b1;  // [R5]
    end else begin
      d.tmr = q.tmr + 32'h1;
    end

    // alert pin: enabled by setup bit 2 alone or kept on by a combined clear
    pin_on  = (q.setup[SETUP_PIN_BIT] && !q.setup[SETUP_CLR_BIT]) || q.pin_kept;  // [R16]
    // polarity bit 0: one drives the pin high on an alert, zero drives it low
    if (q.setup[SETUP_POL_BIT]) begin
      d.alert = pin_on && any_alert;
    end else begin
      d.alert = !(pin_on && any_alert);
    end
  end

  // one register stage for the whole block state
  // synchronous reset: the first edge after release already sees reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      // every field named so the value after reset is visible at a glance
      q.ack      <= 1'b0;
      q.rdat     <= '0;
      q.code     <= {4{CODE_RESET}};
      q.diode_one <= RESULT_RESET[14:0];
      q.diode_two <= RESULT_RESET[14:0];
      q.int_temp <= RESULT_RESET[TEMP_W-1:0];
      q.pin_kept <= 1'b0;
      q.tmr      <= 32'h0;
      q.conv_req <= 1'b0;
      q.setup    <= SETUP_RESET;  // [R19]
      q.seq      <= SEQUENCE_RESET;
      q.st_in    <= ALERT_RESET;
      q.st_cur   <= ALERT_RESET;
      q.st_temp  <= ALERT_RESET;
      q.adc_res  <= RESULT_RESET[14:0];
      q.alert    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // every data output comes straight from the state register
  assign wb_ack_o                   = q.ack;
  assign wb_dat_o                   = q.rdat;
  assign output_a_code_o            = q.code[0];
  assign output_b_code_o            = q.code[1];
  assign output_c_code_o            = q.code[2];
  assign output_d_code_o            = q.code[3];
  assign autocycle_channel_select_o = q.seq;
  assign operating_setup_o          = q.setup;
  assign conv_req_o                 = q.conv_req;
  assign alert_o                    = q.alert;
endmodule
`default_nettype wire

// ===== mrd_pkg.sv
package mrd_pkg;

  // bus geometry: one register per aligned 32-bit word, byte address = 4 * index
  localparam int          WB_ADR_W        = 8;
  localparam int          WB_DAT_W        = 32;
  localparam int          IDX_W           = 4;

  // register indices
  localparam logic [3:0]  IDX_ADC_RESULT  = 4'h1;
  localparam logic [3:0]  IDX_DIODE_ONE   = 4'h2;
  localparam logic [3:0]  IDX_DIODE_TWO   = 4'h3;
  localparam logic [3:0]  IDX_INT_TEMP    = 4'h4;
  localparam logic [3:0]  IDX_OUT_A       = 4'h1;
  localparam logic [3:0]  IDX_OUT_D       = 4'h4;
  localparam logic [3:0]  IDX_ALERT_IN    = 4'h5;
  localparam logic [3:0]  IDX_ALERT_CUR   = 4'h6;
  localparam logic [3:0]  IDX_ALERT_TEMP  = 4'h7;
  localparam logic [3:0]  IDX_SEQUENCE    = 4'h8;
  localparam logic [3:0]  IDX_SETUP       = 4'h9;

  // reset values
  localparam logic [15:0] SETUP_RESET     = 16'h0000;
  localparam logic [7:0]  SEQUENCE_RESET  = 8'h00;
  localparam logic [11:0] CODE_RESET      = 12'h000;
  localparam logic [7:0]  ALERT_RESET     = 8'h00;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  // result word fields
  localparam int          RES_FLAG_BIT    = 15;
  localparam int          RES_TAG_HI      = 14;
  localparam int          RES_TAG_LO      = 12;
  localparam int          RES_OPEN_BIT    = 11;
  localparam int          TEMP_W          = 11;
  localparam int          CODE_W          = 12;
  localparam logic [1:0]  TAG_DIODE_PFX   = 2'h3;
  localparam logic [7:0]  CUR_ALERT_MASK  = 8'h3F;

  // setup register fields
  localparam int          SETUP_POL_BIT   = 0;
  localparam int          SETUP_CLR_BIT   = 1;
  localparam int          SETUP_PIN_BIT   = 2;

  // converter link frame: bit 19 internal sensor, 18:16 tag, 15:0 payload
  localparam int          FRAME_W         = 20;
  localparam int          FRAME_INT_BIT   = 19;
  localparam int          FRAME_TAG_HI    = 18;
  localparam int          FRAME_TAG_LO    = 16;
  localparam logic [4:0]  FRAME_BITS      = 5'h14;

  // refresh timing
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          REFRESH_MS      = 5;
  localparam int          REFRESH_CYCLES  = CLK_HZ / 1000 * REFRESH_MS;

  typedef enum logic [0:0] {
    MRD_RX_IDLE  = 1'b0,
    MRD_RX_SHIFT = 1'b1
  } mrd_rx_state_t;

endpackage

// ===== mrd_frame_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mrd_frame_if;
  import mrd_pkg::*;
  logic               valid;
  logic [FRAME_W-1:0] word;
  modport rx (output valid, output word);
  modport core (input valid, input word);
endinterface
`default_nettype wire

// ===== mrd_link_rx.sv
`timescale 1ns/100ps
`default_nettype none
module mrd_link_rx (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic link_clk_i,
  input  wire logic link_frame_i,
  input  wire logic link_data_i,
  mrd_frame_if.rx   frame
);
  import mrd_pkg::*;

  typedef struct packed {
    logic [2:0]         meta;
    logic [2:0]         sync;
    logic               clk_prev;
    mrd_rx_state_t      state;
    logic [4:0]         cnt;
    logic [FRAME_W-1:0] shreg;
    logic               valid;
    logic [FRAME_W-1:0] word;
  } mrd_rx_regs_t;

  mrd_rx_regs_t q;
  mrd_rx_regs_t d;

  // link pins pass two flops; only the second stage is looked at
  always_comb begin
    d          = q;
    d.meta     = {link_clk_i, link_frame_i, link_data_i};
    d.sync     = q.meta;
    d.clk_prev = q.sync[2];
    d.valid    = 1'b0;
    case (q.state)
      MRD_RX_IDLE: begin
        d.cnt = 5'h00;
        if (q.sync[1]) begin
          d.state = MRD_RX_SHIFT;
        end
      end
      MRD_RX_SHIFT: begin
        // frame end mid-word drops the partial word rather than mixing frames
        if (!q.sync[1]) begin
          d.state = MRD_RX_IDLE;
        end else if (q.sync[2] && !q.clk_prev) begin
          d.shreg = {q.shreg[FRAME_W-2:0], q.sync[0]};
          if (q.cnt == FRAME_BITS - 5'h01) begin
            d.valid = 1'b1;
            d.word  = {q.shreg[FRAME_W-2:0], q.sync[0]};
            d.cnt   = 5'h00;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
      end
      default: d.state = MRD_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign frame.valid = q.valid;
  assign frame.word  = q.word;
endmodule
`default_nettype wire

// ===== mrd_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mrd_regs_chk #(
  parameter int REFRESH_CYCLES_P = mrd_pkg::REFRESH_CYCLES
) (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [mrd_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [mrd_pkg::WB_DAT_W-1:0] wb_dat_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [mrd_pkg::WB_DAT_W-1:0] wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic [11:0]                  output_a_code_o,
  input wire logic [11:0]                  output_d_code_o,
  input wire logic [7:0]                   autocycle_channel_select_o,
  input wire logic [15:0]                  operating_setup_o,
  input wire logic                         conv_req_o,
  input wire logic                         alert_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is taken only while no answer is pending
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_take ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  sequence s_wr(logic [7:0] a);
    s_take ##0 (wb_we_i && wb_sel_i == 4'hF && wb_adr_i == a);
  endsequence
  property p_ack;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_out_a;
    s_wr(8'h04) |=> output_a_code_o == $past(wb_dat_i[11:0]);
  endproperty
  a_out_a: assert property (p_out_a) else $error("output a code wrong");
  property p_out_d;
    s_wr(8'h10) |=> output_d_code_o == $past(wb_dat_i[11:0]);
  endproperty
  a_out_d: assert property (p_out_d) else $error("output d code wrong");
  property p_seq;
    s_wr(8'h20) |=> autocycle_channel_select_o == $past(wb_dat_i[7:0]);
  endproperty
  a_seq: assert property (p_seq) else $error("sequence register wrong");
  property p_setup_rd;
    s_rd(8'h24) |=> wb_dat_o == {16'h0000, operating_setup_o};
  endproperty
  a_setup_rd: assert property (p_setup_rd) else $error("setup readback wrong");
  property p_cur_rd;
    s_rd(8'h18) |=> wb_dat_o[31:6] == 26'h0000000;
  endproperty
  a_cur_rd: assert property (p_cur_rd) else $error("current status high bits set");
  property p_int_rd;
    s_rd(8'h10) |=> wb_dat_o[14:11] == 4'h0 && wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_int_rd: assert property (p_int_rd) else $error("internal result pad bits set");
  // cycles since the last refresh pulse; a long period is counted, not unrolled
  logic        seen_q;
  logic [31:0] gap_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
      gap_q  <= 32'h0;
    end else if (conv_req_o) begin
      seen_q <= 1'b1;
      gap_q  <= 32'h0;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  // after the first pulse, a pulse comes exactly when the gap reaches the period minus one
  property p_refresh;
    seen_q |-> conv_req_o == (gap_q == 32'(REFRESH_CYCLES_P - 1));
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh spacing wrong");
  property p_rst;
    disable iff (1'b0) rst_i |=> alert_o && operating_setup_o == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind mrd_regs mrd_regs_chk #(.REFRESH_CYCLES_P(REFRESH_CYCLES_P)) i_mrd_regs_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_a_code_o(output_a_code_o),
  .output_d_code_o(output_d_code_o), .autocycle_channel_select_o(autocycle_channel_select_o),
  .operating_setup_o(operating_setup_o), .conv_req_o(conv_req_o), .alert_o(alert_o));
`default_nettype wire

// ===== mrd_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module mrd_link_model (
  output logic link_clk_o,
  output logic link_frame_o,
  output logic link_data_o
);
  initial begin
    link_clk_o = 1'b0;
    link_frame_o = 1'b0;
    link_data_o = 1'b0;
  end
  // clock stands low outside frames; data flips after release so no stale bit
  task automatic send(input logic [19:0] w);
    link_frame_o = 1'b1;
    #160;
    for (int i = 19; i >= 0; i--) begin
      link_data_o = w[i];
      #160 link_clk_o = 1'b1;
      #160 link_clk_o = 1'b0;
    end
    #160 link_frame_o = 1'b0;
    link_data_o = ~link_data_o;
    #400;
  endtask
endmodule
`default_nettype wire

// ===== tb_mrd_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mrd_regs;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, conv_req_o, alert_o;
  logic [7:0]  wb_adr_i = 8'h00, input_alert_set_i = 8'h00, autocycle_channel_select_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [5:0]  current_alert_set_i = 6'h00;
  logic [6:0]  temperature_alert_set_i = 7'h00;
  logic [11:0] code_a, code_b, code_c, code_d;
  logic [15:0] operating_setup_o;
  wire         lclk, lframe, ldata;
  wire  [47:0] codes_w = {code_d, code_c, code_b, code_a};
  int          error_cnt = 0, comparisons = 0;
  localparam int REFRESH_SIM = 32'h32;  // short refresh period keeps the run small
  always #20 clk_i = ~clk_i;
  mrd_regs #(.REFRESH_CYCLES_P(REFRESH_SIM)) i_mrd_regs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(lclk), .link_frame_i(lframe),
    .link_data_i(ldata), .input_alert_set_i(input_alert_set_i),
    .current_alert_set_i(current_alert_set_i),
    .temperature_alert_set_i(temperature_alert_set_i), .output_a_code_o(code_a),
    .output_b_code_o(code_b), .output_c_code_o(code_c), .output_d_code_o(code_d),
    .autocycle_channel_select_o(autocycle_channel_select_o),
    .operating_setup_o(operating_setup_o), .conv_req_o(conv_req_o), .alert_o(alert_o));
  mrd_link_model i_mrd_link_model (.link_clk_o(lclk), .link_frame_o(lframe), .link_data_o(ldata));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (n >= 50) begin
      error_cnt++;
      close_out;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic al(input logic [7:0] a, input logic [5:0] c, input logic [6:0] t);
    @(posedge clk_i);
    input_alert_set_i <= a;
    current_alert_set_i <= c;
    temperature_alert_set_i <= t;
    @(posedge clk_i);
    {input_alert_set_i, current_alert_set_i, temperature_alert_set_i} <= 21'h0;
  endtask
  // main sequence: reset, codes, results, alert status, combined clear
  initial begin
    int n;
    logic [31:0] e;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h24, 32'h0, "setup");
    rc(8'h20, 32'h0, "sequence");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      e = 32'(12'h111) * (i + 1);
      wb(1'b1, 8'(4 * i + 4), 32'hFFFF_F000 | e);
      chk("code", e, {20'h0, codes_w[i*12+:12]});
    end
    wb(1'b1, 8'h2C, 32'hFFFF);
    rc(8'h2C, 32'h0, "unmapped");
    wb(1'b1, 8'h20, 32'h0000_01C3);
    rc(8'h20, 32'hC3, "sequence");
    chk("sequence out", 32'hC3, {24'h0, autocycle_channel_select_o});
    wb(1'b1, 8'h24, 32'h0001_8001);
    rc(8'h24, 32'h8001, "setup");
    chk("setup out", 32'h8001, {16'h0, operating_setup_o});
    $display("test registers done");
    i_mrd_link_model.send({1'b0, 3'b110, 5'h00, 11'h7FF});
    rc(8'h08, 32'h67FF, "diode one");
    i_mrd_link_model.send({1'b0, 3'b111, 4'h0, 1'b1, 11'h400});
    rc(8'h0C, 32'hFC00, "diode two");
    rc(8'h1C, 32'h80, "temp status");
    i_mrd_link_model.send({1'b1, 3'b000, 16'h7FFF});
    rc(8'h10, 32'h87FF, "internal");
    i_mrd_link_model.send({1'b0, 3'b010, 16'h0ABC});
    rc(8'h04, 32'hAABC, "adc result");
    n = 0;
    while (conv_req_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("refresh", 32'h1, {31'h0, conv_req_o});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (conv_req_o !== 1'b1 && n < 100);
    chk("refresh gap", 32'(REFRESH_SIM), 32'(n));
    $display("test results done");
    al(8'hA5, 6'h3F, 7'h00);
    rc(8'h14, 32'hA5, "input status");
    wb(1'b1, 8'h14, 32'h01);
    rc(8'h14, 32'hA4, "input status");
    wb(1'b1, 8'h14, 32'hFF);
    rc(8'h14, 32'h0, "input status");
    rc(8'h18, 32'h3F, "current status");
    wb(1'b1, 8'h24, 32'h0006);
    rc(8'h18, 32'h0, "current status");
    rc(8'h1C, 32'h0, "temp status");
    al(8'h00, 6'h00, 7'h01);
    repeat (3) @(posedge clk_i);
    chk("alert pin", 32'h0, {31'h0, alert_o});
    wb(1'b1, 8'h1C, 32'h01);
    repeat (3) @(posedge clk_i);
    chk("alert pin", 32'h1, {31'h0, alert_o});
    $display("test alerts done");
    close_out;
  end
endmodule
`default_nettype wire
